// [testbench/codec_parallel_playback_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module codec_parallel_playback_port_tb;
  import cpp_pkg::*;
  localparam int INIT_N = 20;
  logic        clk;
  logic        sys_rst;
  cpp_host_s   host_in;
  logic [7:0]  data_out;
  logic        data_oe;
  logic        playback_request;
  logic [7:0]  direct_io_out;
  logic        sample_valid;
  logic        sample_ready;
  cpp_sample_s sample_data;
  int          num_errors;
  int          comparisons;
  logic [31:0] sent_q[$];
  logic [31:0] got_q[$];

  cpp_port #(.INIT_CYCLES(INIT_N)) i_cpp_port (
    .clk(clk), .sys_rst(sys_rst), .host_in(host_in), .data_out(data_out),
    .data_oe(data_oe), .playback_request(playback_request),
    .direct_io_out(direct_io_out), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data));

  cpp_host_model i_cpp_host_model (
    .clk(clk), .playback_request(playback_request), .data_out(data_out), .host(host_in));

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Collect every pair handed to the consumer
  always @(posedge clk) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
      got_q.push_back(sample_data);
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Wait for all sent pairs, then compare them in order
  task automatic drain();
    for (int i = 0; i < 200 && got_q.size() < sent_q.size(); i++) @(negedge clk);
    check(got_q.size(), sent_q.size(), "pair count");
    while (sent_q.size() > 0 && got_q.size() > 0) begin
      check(got_q.pop_front(), sent_q.pop_front(), "pair");
    end
  endtask

  task automatic t_init();
    logic [7:0] d;
    i_cpp_host_model.rd(CPP_SEL_INDEX, d);
    check(d, CPP_INIT_READ, "busy pointer");
    for (int i = 0; i < 10 && d === CPP_INIT_READ; i++) i_cpp_host_model.rd(CPP_SEL_INDEX, d);
    check(d, 8'h00, "pointer after init");
  endtask

  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] s;
    i_cpp_host_model.wr(CPP_SEL_INDEX, 8'h05);
    i_cpp_host_model.wr(CPP_SEL_WINDOW, 8'hC3);
    i_cpp_host_model.wr(CPP_SEL_INDEX, 8'h15);
    i_cpp_host_model.wr(CPP_SEL_WINDOW, 8'h77);
    i_cpp_host_model.rd(CPP_SEL_INDEX, d);
    check(d, 8'h15, "pointer readback");
    i_cpp_host_model.wr(CPP_SEL_INDEX, 8'h05);
    i_cpp_host_model.rd(CPP_SEL_WINDOW, d);
    check(d, 8'hC3, "window lower slot");
    i_cpp_host_model.wr(CPP_SEL_DIO, 8'h3C);
    check(direct_io_out, 8'h3C, "direct io out");
    i_cpp_host_model.rd(CPP_SEL_DIO, d);
    check(d, 8'h3C, "direct io read");
    i_cpp_host_model.rd(CPP_SEL_STATUS, s);
    i_cpp_host_model.wr(CPP_SEL_STATUS, ~s);
    i_cpp_host_model.rd(CPP_SEL_STATUS, d);
    check(d, s, "status write ignored");
  endtask

  // Format change starts the settling routine; poll the pointer until it clears
  task automatic t_settle();
    logic [7:0] d;
    i_cpp_host_model.wr(CPP_SEL_INDEX, {3'h0, CPP_REG_FORMAT});
    i_cpp_host_model.wr(CPP_SEL_WINDOW, 8'h4A);
    i_cpp_host_model.rd(CPP_SEL_INDEX, d);
    check(d, CPP_INIT_READ, "pointer while settling");
    for (int i = 0; i < 1000 && d === CPP_INIT_READ; i++) begin
      i_cpp_host_model.rd(CPP_SEL_INDEX, d);
    end
    check(d, {3'h0, CPP_REG_FORMAT}, "pointer after settling");
    i_cpp_host_model.rd(CPP_SEL_WINDOW, d);
    check(d, 8'h4A, "format slot");
  endtask

  // Enable playback and send boundary pairs back to back
  task automatic t_play();
    logic seen;
    logic drop;
    logic [31:0] tbl[3] = '{32'h8000_7FFF, 32'hFFFF_0000, 32'h1234_ABCD};
    i_cpp_host_model.wr(CPP_SEL_INDEX, {3'h0, CPP_REG_PLAY});
    i_cpp_host_model.wr(CPP_SEL_WINDOW, 8'h01);
    foreach (tbl[i]) begin
      i_cpp_host_model.burst(tbl[i], seen, drop);
      check(seen, 1'b1, "request raised");
      check(drop, 1'b1, "request dropped");
      sent_q.push_back(tbl[i]);
    end
    drain();
  endtask

  // Stall the consumer until the store refuses, then drain
  task automatic t_fill();
    logic seen;
    logic drop;
    logic [7:0] d;
    int n;
    n = 0;
    sample_ready = 1'b0;
    for (int k = 0; k < 22; k++) begin
      i_cpp_host_model.burst({8'(k), 8'h11, 8'(k), 8'h22}, seen, drop);
      if (!seen) break;
      sent_q.push_back({8'(k), 8'h11, 8'(k), 8'h22});
      n++;
    end
    // Store depth plus the two-entry output stage
    check(n, CPP_FIFO_DEPTH + 2, "stored pairs");
    i_cpp_host_model.rd(CPP_SEL_STATUS, d);
    check(d[CPP_ST_FULL], 1'b1, "full flag");
    sample_ready = 1'b1;
    drain();
  endtask

  // Request served between pointer and window write, then stop
  task automatic t_stop();
    logic seen;
    logic drop;
    logic [7:0] d;
    i_cpp_host_model.wr(CPP_SEL_INDEX, {3'h0, CPP_REG_PLAY});
    i_cpp_host_model.burst(32'h0102_0304, seen, drop);
    sent_q.push_back(32'h0102_0304);
    i_cpp_host_model.rd(CPP_SEL_INDEX, d);
    check(d, {3'h0, CPP_REG_PLAY}, "pointer kept under ack");
    i_cpp_host_model.wr(CPP_SEL_WINDOW, 8'h00);
    if (playback_request === 1'b1) begin
      i_cpp_host_model.burst(32'h0506_0708, seen, drop);
      sent_q.push_back(32'h0506_0708);
    end
    drain();
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      if (playback_request !== 1'b0) begin
        num_errors++;
        $display("FAIL %0t request after stop", $time);
        break;
      end
    end
    comparisons++;
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    sample_ready = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_init();
    t_regs();
    t_settle();
    t_play();
    t_fill();
    t_stop();
    wrap_up();
  end

  // Watchdog, well past the expected run
  initial begin
    #500_000;
    num_errors++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire

// [testbench/cpp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_host_model (
  input  wire logic                clk,
  input  wire logic                playback_request,
  input  wire logic [7:0]          data_out,
  output var  cpp_pkg::cpp_host_s  host
);
  import cpp_pkg::*;

  // Glue inputs that form the read strobe
  logic page_addr_bit16;
  logic page_addr_bit17;
  logic program_store_strobe_n;

  // Bus idle: strobes high, acknowledge released, program page selected
  initial begin
    host.data              = 8'hA5;
    host.reg_select_lines  = 2'h0;
    host.wr_n              = 1'b1;
    host.rd_n              = 1'b1;
    host.playback_ack_n    = 1'b1;
    page_addr_bit16        = 1'b1;
    page_addr_bit17        = 1'b1;
    program_store_strobe_n = 1'b1;
  end

  // One write, 100 ns low inside a 200 ns period
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge clk);
    host.reg_select_lines = sel;
    host.data = d;
    host.wr_n = 1'b0;
    repeat (4) @(negedge clk);
    host.wr_n = 1'b1;
    repeat (3) @(negedge clk);
    host.data = ~d; // Released bus shows no stale byte
  endtask

  // One read, data taken while the strobe is still low
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(negedge clk);
    host.reg_select_lines = sel; // Only the select lines reach the device
    page_addr_bit16 = 1'b0; // Codec sits in page 00
    page_addr_bit17 = 1'b0;
    program_store_strobe_n = 1'b0;
    host.rd_n = page_addr_bit16 | page_addr_bit17 | program_store_strobe_n;
    repeat (3) @(negedge clk);
    d = data_out;
    program_store_strobe_n = 1'b1;
    page_addr_bit16 = 1'b1; // Back to the program page
    page_addr_bit17 = 1'b1;
    host.rd_n = page_addr_bit16 | page_addr_bit17 | program_store_strobe_n;
    @(negedge clk);
  endtask

  // Serve one request with a whole pair; select lines left at 0
  task automatic burst(input logic [31:0] smp, output logic seen, output logic dropped);
    int n;
    n = 0;
    seen = 1'b0;
    dropped = 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (playback_request !== 1'b1 && n < 200);
    if (playback_request !== 1'b1) return;
    seen = 1'b1;
    host.playback_ack_n = 1'b0;
    for (int i = 0; i < 4; i++) wr(2'h0, smp[8*i +: 8]);
    dropped = (playback_request === 1'b0);
    host.playback_ack_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [verilog/cpp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              full,
  output logic              empty
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_MAX = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } cpp_fifo_s;

  cpp_fifo_s s_q, s_d;
  logic push, pop;

  // Flags follow the occupancy count
  assign full      = (s_q.cnt == CNT_MAX);
  assign empty     = (s_q.cnt == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Ring storage with wrapping pointers
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.cnt <= CNT_MAX) else $error("sample store over depth");
endmodule
`default_nettype wire

// [verilog/cpp_pkg.sv]
// How it works
// - Buffer sixteen stereo pairs, sixty-four bytes total; the code holds eighteen, sixteen in the store and two in the output stage
// - Bytes arrive left low, left high, right low, right high
// - Two select lines pick one of four registers
// - Thirty-two control registers reached through the pointer
// - Request data while the buffer has room
// - Bytes captured on write strobe rising edge
// - Request drops at last strobe falling edge
// - Acknowledge low overrides select, writes go buffer
// - Pointer reads 80h for 512 ms after reset
`default_nettype none
package cpp_pkg;
  localparam int CPP_DATA_W       = 8;
  localparam int CPP_FIFO_DEPTH   = 16;
  localparam int CPP_BYTES_PER_SMP = 4;
  localparam int CPP_NUM_REGS     = 32;
  localparam int CPP_IDX_W        = 4;
  localparam int CPP_PTR_W        = 5;
  // Direct register selects
  localparam logic [1:0] CPP_SEL_INDEX  = 2'h0;
  localparam logic [1:0] CPP_SEL_WINDOW = 2'h1;
  localparam logic [1:0] CPP_SEL_STATUS = 2'h2;
  localparam logic [1:0] CPP_SEL_DIO    = 2'h3;
  // Indirect register slots and fields
  localparam logic [4:0] CPP_REG_FORMAT  = 5'h08;
  localparam logic [4:0] CPP_REG_PLAY    = 5'h09;
  localparam int         CPP_PLAY_EN_BIT = 0;
  // Status bit positions
  localparam int CPP_ST_EMPTY = 0;
  localparam int CPP_ST_FULL  = 1;
  localparam int CPP_ST_BUSY  = 2;
  localparam int CPP_ST_REQ   = 3;
  // Reset and fixed read values
  localparam logic [7:0] CPP_INIT_READ  = 8'h80;
  localparam logic [7:0] CPP_REG_RESET  = 8'h00;
  // Timing
  localparam int CPP_CLK_KHZ         = 40000;
  localparam int CPP_INIT_TIME_MS    = 512;
  localparam int CPP_INIT_CYCLES     = CPP_INIT_TIME_MS * CPP_CLK_KHZ;
  localparam int CPP_SETTLE_TIME_US  = 100;
  localparam int CPP_SETTLE_CYCLES   = (CPP_SETTLE_TIME_US * CPP_CLK_KHZ) / 1000;
  localparam int CPP_TMR_W           = 25;

  typedef struct packed {
    logic [15:0] right;
    logic [15:0] left;
  } cpp_sample_s;

  typedef struct packed {
    logic [7:0] data;
    logic [1:0] reg_select_lines;
    logic       wr_n;
    logic       rd_n;
    logic       playback_ack_n;
  } cpp_host_s;

  typedef enum logic [1:0] {
    CPP_LK_IDLE,
    CPP_LK_REQ,
    CPP_LK_XFER,
    CPP_LK_DONE
  } cpp_link_e;
endpackage
`default_nettype wire

// [verilog/cpp_port.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_port #(
  parameter int INIT_CYCLES = cpp_pkg::CPP_INIT_CYCLES,
  parameter int FIFO_DEPTH  = cpp_pkg::CPP_FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire cpp_pkg::cpp_host_s   host_in,
  output logic [7:0]                data_out,
  output logic                      data_oe,
  output logic                      playback_request,
  output logic [7:0]                direct_io_out,
  output logic                      sample_valid,
  input  wire logic                 sample_ready,
  output cpp_pkg::cpp_sample_s      sample_data
);
  import cpp_pkg::*;

  typedef struct packed {
    cpp_link_e                       link;
    logic [1:0]                      byte_cnt;
    logic [23:0]                     asm_bytes;
    logic [7:0]                      wr_hold;
    logic                            wr_prev;
    logic [CPP_PTR_W-1:0]            index_ptr;
    logic [CPP_NUM_REGS-1:0][7:0]    ctrl;
    logic [7:0]                      dio;
    logic [CPP_TMR_W-1:0]            busy_cnt;
    logic                            req;
    logic [7:0]                      dout;
    logic                            doe;
    logic                            push;
    cpp_sample_s                     push_data;
  } cpp_port_s;

  cpp_port_s   s_q, s_d;
  logic        wr_rise, wr_fall, busy, play_en;
  logic        fifo_in_ready, fifo_out_valid, fifo_full, fifo_empty;
  logic        skid_in_ready;
  cpp_sample_s fifo_out_data;
  logic [7:0]  rd_mux;
  logic [7:0]  status;

  // Strobe edges seen against the previous sample of the pin
  assign wr_rise = !s_q.wr_prev && host_in.wr_n;
  assign wr_fall = s_q.wr_prev && !host_in.wr_n;
  assign busy    = (s_q.busy_cnt != '0);
  assign play_en = s_q.ctrl[CPP_REG_PLAY][CPP_PLAY_EN_BIT];

  // Status byte shows buffer and handshake state
  always_comb begin
    status = '0;
    status[CPP_ST_EMPTY] = fifo_empty;
    status[CPP_ST_FULL]  = fifo_full;
    status[CPP_ST_BUSY]  = busy;
    status[CPP_ST_REQ]   = s_q.req;
  end

  // Read data selected by the two select lines
  always_comb begin
    case (host_in.reg_select_lines)
      CPP_SEL_INDEX:  rd_mux = busy ? CPP_INIT_READ : 8'(s_q.index_ptr);
      CPP_SEL_WINDOW: rd_mux = s_q.ctrl[s_q.index_ptr];
      CPP_SEL_STATUS: rd_mux = status;
      CPP_SEL_DIO:    rd_mux = s_q.dio;
      default:        rd_mux = '0;
    endcase
  end

  // Register access, byte assembly and the request handshake
  always_comb begin
    s_d         = s_q;
    s_d.wr_prev = host_in.wr_n;
    s_d.push    = 1'b0;
    s_d.doe     = !host_in.rd_n && host_in.playback_ack_n;
    if (!host_in.rd_n) begin
      s_d.dout = rd_mux;
    end
    if (!host_in.wr_n) begin
      s_d.wr_hold = host_in.data; // Byte held while strobe is low
    end
    if (busy) begin
      s_d.busy_cnt = s_q.busy_cnt - 1'b1;
    end

    // Register writes only when no playback acknowledge is present
    if (wr_rise && host_in.playback_ack_n) begin
      case (host_in.reg_select_lines)
        CPP_SEL_INDEX: begin
          s_d.index_ptr = s_q.wr_hold[CPP_PTR_W-1:0];
        end
        CPP_SEL_WINDOW: begin
          s_d.ctrl[s_q.index_ptr] = s_q.wr_hold;
          if (s_q.index_ptr == CPP_REG_FORMAT) begin
            s_d.busy_cnt = CPP_TMR_W'(CPP_SETTLE_CYCLES);
          end
        end
        CPP_SEL_DIO: begin
          s_d.dio = s_q.wr_hold;
        end
        default: begin
          s_d.dio = s_q.dio; // Status is read only
        end
      endcase
    end

    case (s_q.link)
      CPP_LK_IDLE: begin
        // Ask for a pair only when the store can take it
        if (play_en && !busy && fifo_in_ready && !s_q.push && host_in.playback_ack_n) begin
          s_d.req  = 1'b1;
          s_d.link = CPP_LK_REQ;
        end
      end
      CPP_LK_REQ: begin
        if (!host_in.playback_ack_n) begin
          s_d.link     = CPP_LK_XFER;
          s_d.byte_cnt = '0;
        end
      end
      CPP_LK_XFER: begin
        if (wr_fall && s_q.byte_cnt == 2'(CPP_BYTES_PER_SMP-1)) begin
          s_d.req = 1'b0;
        end
        if (wr_rise && !host_in.playback_ack_n) begin
          s_d.byte_cnt = s_q.byte_cnt + 1'b1;
          if (s_q.byte_cnt == 2'(CPP_BYTES_PER_SMP-1)) begin
            // Last byte completes left low, left high, right low, right high
            s_d.push_data = {s_q.wr_hold, s_q.asm_bytes};
            s_d.push      = 1'b1;
            s_d.link      = CPP_LK_DONE;
          end else begin
            s_d.asm_bytes = {s_q.wr_hold, s_q.asm_bytes[23:8]};
          end
        end
      end
      CPP_LK_DONE: begin
        if (host_in.playback_ack_n) begin
          s_d.link = CPP_LK_IDLE;
        end
      end
      default: begin
        s_d.link = CPP_LK_IDLE;
        s_d.req  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.wr_prev  <= 1'b1;
      s_q.link     <= CPP_LK_IDLE;
      s_q.busy_cnt <= CPP_TMR_W'(INIT_CYCLES);
    end else begin
      s_q <= s_d;
    end
  end

  // Sixteen pair sample store
  cpp_fifo #(
    .W     ($bits(cpp_sample_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_store (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (s_q.push),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.push_data),
    .out_valid (fifo_out_valid),
    .out_ready (skid_in_ready),
    .out_data  (fifo_out_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  // Output stage so a stalled consumer drops nothing
  cpp_skid #(
    .W ($bits(cpp_sample_s))
  ) u_out (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_out_valid),
    .in_ready  (skid_in_ready),
    .in_data   (fifo_out_data),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_data)
  );

  assign data_out         = s_q.dout;
  assign data_oe          = s_q.doe;
  assign playback_request = s_q.req;
  assign direct_io_out    = s_q.dio;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_init_reads_80: assert property (!host_in.rd_n && host_in.playback_ack_n && busy &&
    host_in.reg_select_lines == CPP_SEL_INDEX |=> data_oe && data_out == CPP_INIT_READ)
    else $error("pointer not 80h while busy");
  a_req_drop_last: assert property (s_q.link == CPP_LK_XFER && wr_fall &&
    s_q.byte_cnt == 2'd3 |=> !playback_request)
    else $error("request held after last strobe fall");
  a_pair_order: assert property (s_q.link == CPP_LK_XFER && wr_rise &&
    !host_in.playback_ack_n && s_q.byte_cnt == 2'd3
    |=> s_q.push && s_q.push_data.right[15:8] == $past(s_q.wr_hold)
        && s_q.push_data.left == $past(s_q.asm_bytes[15:0]))
    else $error("sample bytes misordered");
  a_req_needs_room: assert property ($rose(playback_request) |->
    $past(fifo_in_ready) && $past(play_en) && !$past(busy))
    else $error("request raised without room");
  a_ack_blocks_regs: assert property (!host_in.playback_ack_n && wr_rise
    |=> $stable(s_q.index_ptr) && $stable(s_q.dio))
    else $error("register written during acknowledge");
  a_index_load: assert property (host_in.playback_ack_n && wr_rise &&
    host_in.reg_select_lines == CPP_SEL_INDEX
    |=> s_q.index_ptr == $past(s_q.wr_hold[CPP_PTR_W-1:0]))
    else $error("pointer not loaded");
  a_window_load: assert property (host_in.playback_ack_n && wr_rise &&
    host_in.reg_select_lines == CPP_SEL_WINDOW
    |=> s_q.ctrl[$past(s_q.index_ptr)] == $past(s_q.wr_hold))
    else $error("window write lost");
  a_fall_no_capture: assert property (s_q.link == CPP_LK_XFER && wr_fall
    |=> $stable(s_q.byte_cnt))
    else $error("byte taken on falling edge");
  a_push_one_cycle: assert property (s_q.push |=> !s_q.push [*2])
    else $error("pair pushed twice");

  // Bus is driven one cycle after a read strobe
  a_oe_on_read: assert property (!host_in.rd_n && host_in.playback_ack_n
    |=> data_oe)
    else $error("read strobe not answered");

  // Bus is released once the read strobe is gone
  a_oe_off_idle: assert property (host_in.rd_n
    |=> !data_oe)
    else $error("bus driven without read strobe");

  // Acknowledge keeps the device off the bus
  a_oe_off_ack: assert property (!host_in.playback_ack_n
    |=> !data_oe)
    else $error("bus driven under acknowledge");

  // Window read returns the slot named by the pointer
  a_window_read: assert property (!host_in.rd_n && host_in.playback_ack_n &&
    host_in.reg_select_lines == CPP_SEL_WINDOW |=> data_out == $past(s_q.ctrl[s_q.index_ptr]))
    else $error("window read wrong slot");

  // Direct io register takes the held byte
  a_dio_load: assert property (host_in.playback_ack_n && wr_rise &&
    host_in.reg_select_lines == CPP_SEL_DIO |=> direct_io_out == $past(s_q.wr_hold))
    else $error("direct io write lost");

  // Status select writes nothing
  a_status_ro: assert property (wr_rise && host_in.reg_select_lines == CPP_SEL_STATUS
    |=> $stable(s_q.dio) && $stable(s_q.index_ptr) && $stable(s_q.ctrl))
    else $error("status write reached a register");

  // Control slots are frozen while acknowledge is low
  a_ack_keeps_ctrl: assert property (!host_in.playback_ack_n && wr_rise
    |=> $stable(s_q.ctrl))
    else $error("control slot written during acknowledge");

  // Format write starts the settling period
  a_settle_start: assert property (host_in.playback_ack_n && wr_rise &&
    host_in.reg_select_lines == CPP_SEL_WINDOW && s_q.index_ptr == CPP_REG_FORMAT |=> busy)
    else $error("settling not started");

  // Busy time runs down one step per clock
  a_busy_steps: assert property (busy && !wr_rise
    |=> s_q.busy_cnt == $past(s_q.busy_cnt) - 1'b1)
    else $error("busy count skipped");

  // Request stands until the last strobe of its burst falls
  a_req_stands: assert property (playback_request &&
    !(s_q.link == CPP_LK_XFER && wr_fall && s_q.byte_cnt == 2'd3) |=> playback_request)
    else $error("request dropped early");

  // No new request until acknowledge has been released
  a_req_low_done: assert property (s_q.link == CPP_LK_DONE |-> !playback_request)
    else $error("request raised before release");

  // Playback off in idle raises no request
  a_idle_quiet: assert property (!play_en && s_q.link == CPP_LK_IDLE
    |=> !playback_request)
    else $error("request while playback off");

  // Every strobe rise under acknowledge takes one byte
  a_byte_step: assert property (s_q.link == CPP_LK_XFER && wr_rise &&
    !host_in.playback_ack_n |=> s_q.byte_cnt == $past(s_q.byte_cnt) + 2'd1)
    else $error("byte not counted");

  // A finished pair always finds room in the store
  a_push_room: assert property (s_q.push |-> fifo_in_ready)
    else $error("pair pushed into a full store");

  // Main scenarios reached by the bench
  c_burst_done: cover property (s_q.link == CPP_LK_XFER ##[1:200] s_q.push);
  c_store_full: cover property (fifo_full);
  c_out_stall:  cover property (sample_valid && !sample_ready ##1 sample_valid);
  c_settle_end: cover property ($fell(busy));
  c_stop_burst: cover property (s_q.link == CPP_LK_XFER && !play_en);
endmodule
`default_nettype wire

// [verilog/cpp_skid.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_skid #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] ent;
    logic [1:0]        vld;
  } cpp_skid_s;

  cpp_skid_s s_q, s_d;
  logic push, pop;

  assign in_ready  = !s_q.vld[1];
  assign out_valid = s_q.vld[0];
  assign out_data  = s_q.ent[0];
  assign push      = in_valid && in_ready;
  assign pop       = s_q.vld[0] && out_ready;

  // Two entries; head always sits in entry 0 so output is a register
  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.ent[0] = s_q.ent[1];
      s_d.vld    = {1'b0, s_q.vld[1]};
    end
    if (push) begin
      if (!s_d.vld[0]) begin
        s_d.ent[0] = in_data;
        s_d.vld[0] = 1'b1;
      end else begin
        s_d.ent[1] = in_data;
        s_d.vld[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire
